/* File: dv/bsic_checker.sv */
/*
  Bus-side properties of the slot element codec.
  Assumes one AHB-Lite master and hready tied to hreadyout.
*/
module bsic_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_ff;
  logic [7:0] ofs_ff;
  wire logic rd_take = hsel && htrans[1] && !hwrite && hready;
  // Data phase of a read is the cycle after its address edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ff <= 1'b0;
      ofs_ff <= 8'h00;
    end else begin
      rd_ff <= rd_take;
      ofs_ff <= {haddr[7:2], 2'h0};
    end
  end
  wire logic rd_st = rd_ff && ofs_ff == bsic_pkg::OFS_STATUS;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  a_status_rsv: assert property (rd_st |-> hrdata[31:10] == 22'h000000
    && hrdata[7:6] == 2'h0) else $error("status reserved bits set");
  a_kind_found: assert property (rd_st && hrdata[0] && !hrdata[1]
    |-> hrdata[9:8] != 2'h0) else $error("known element without kind");
  a_err_done: assert property (rd_st && hrdata[5:1] != 5'h00
    |-> hrdata[0]) else $error("error flag without done");
  a_field_width: assert property (rd_ff
    && ofs_ff == bsic_pkg::OFS_DEC_FIELD |-> hrdata[31:21] == 11'h000
    && hrdata[15:14] == 2'h0) else $error("decoded field too wide");
  a_unmapped_zero: assert property (rd_ff && ofs_ff >= 8'h2C
    |-> hrdata == 32'h00000000) else $error("unmapped read not zero");
  a_start_clear: assert property (rd_ff
    && ofs_ff == bsic_pkg::OFS_CTRL |-> hrdata[1:0] == 2'h0)
    else $error("start bit reads back set");
  a_hold_data: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  c_pair: cover property (rd_st && hrdata[bsic_pkg::ST_PAIR]);
  c_basic: cover property (rd_st && hrdata[bsic_pkg::ST_BASIC]);
  c_map: cover property (rd_st && hrdata[9:8] == 2'h3);
endmodule : bsic_checker

bind bsic_top bsic_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

/* File: dv/bsic_peer.sv */
/*
  Far-end element source: octet images as the peer entity sends them.
  Combinational; the bench holds its inputs.
*/
module bsic_peer (
  input wire logic [1:0] kind,
  input wire logic [7:0] link,
  input wire logic [4:0] v5_slot,
  input wire logic ovr,
  input wire logic [4:0] uslot,
  input wire logic [31:0] v5_map,
  input wire logic [31:0] up_map,
  output logic [31:0] w0,
  output logic [31:0] w1,
  output logic [31:0] w2
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    w1 = 32'h00000000;
    w2 = 32'h00000000;
    case (kind)
      2'h1: w0 = {11'h000, uslot, bsic_pkg::CLEN_USLOT,
        bsic_pkg::ID_USLOT};
      2'h2: w0 = {2'h0, ovr, v5_slot, link,
        bsic_pkg::CLEN_V5SLOT, bsic_pkg::ID_V5SLOT};
      default: begin
        w0 = {v5_map[31:24], link, bsic_pkg::CLEN_MAP,
          bsic_pkg::ID_MAP};
        // Slot 0 position is forced low whatever the map holds
        w1 = {up_map[31:24], v5_map[7:1], 1'b0, v5_map[15:8],
          v5_map[23:16]};
        w2 = {8'h00, up_map[7:1], 1'b0, up_map[15:8], up_map[23:16]};
      end
    endcase
  end
endmodule : bsic_peer

/* File: dv/bsic_tb_top.sv */
/*
  Bench for the slot element codec: AHB-Lite master tasks, peer images
  and a reference of expected fields and status.
  Assumes bsic_top, bsic_peer and the bound checker.
*/
module bsic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ovr;
  logic [1:0] htrans, kind;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v5m, upm, w0, w1, w2, st, fld;
  logic [7:0] link;
  logic [4:0] slot, uslot;
  logic [15:0] seed;
  int errors, samples_checked, cyc;
  assign hready = hreadyout;
  bsic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  bsic_peer peer (.kind(kind), .link(link), .v5_slot(slot), .ovr(ovr),
    .uslot(uslot), .v5_map(v5m), .up_map(upm), .w0(w0), .w1(w1), .w2(w2));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask : rd_chk
  // Two idle cycles let the check land before status is read
  task automatic dec(input logic [31:0] i0, i1, i2, input logic b);
    wr(bsic_pkg::OFS_OCT_W0, i0);
    wr(bsic_pkg::OFS_OCT_W1, i1);
    wr(bsic_pkg::OFS_OCT_W2, i2);
    wr(bsic_pkg::OFS_CTRL, {27'h0, b, 4'h2});
    repeat (2) @(posedge hclk);
    xfer(bsic_pkg::OFS_STATUS, 1'b0, 32'h0, st);
  endtask : dec
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 16'h004F;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(bsic_pkg::OFS_STATUS, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd_chk(8'h30, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      kind = 2'(i % 3 + 1);
      {ovr, slot, link} = seed[13:0];
      uslot = (seed[15:11] == 5'h00) ? 5'h01 : seed[15:11];
      seed = lfsr(seed);
      v5m = {seed, seed} & (i[1] ? 32'hFFFFFFFE : 32'h00000006);
      upm = {v5m[30:1], v5m[31], 1'b0};
      wr(bsic_pkg::OFS_ENC_FIELD, {11'h0, uslot, 2'h0, ovr, slot, link});
      wr(bsic_pkg::OFS_ENC_V5MAP, v5m);
      wr(bsic_pkg::OFS_ENC_UPMAP, upm);
      wr(bsic_pkg::OFS_CTRL, {27'h0, 1'b0, kind, 2'h1});
      repeat (2) @(posedge hclk);
      rd_chk(bsic_pkg::OFS_STATUS, {22'h0, kind, 8'h01});
      rd_chk(bsic_pkg::OFS_OCT_W0, w0);
      rd_chk(bsic_pkg::OFS_OCT_W1, w1);
      rd_chk(bsic_pkg::OFS_OCT_W2, w2);
      dec(w0, w1, w2, 1'b0);
      chk(st, {22'h0, kind, 8'h01});
      fld = kind == 2'h1 ? {11'h0, uslot, 16'h0} : {18'h0, ovr, slot, link};
      if (kind == 2'h3) fld = {24'h0, link};
      rd_chk(bsic_pkg::OFS_DEC_FIELD, fld);
      rd_chk(bsic_pkg::OFS_DEC_V5MAP, kind == 2'h3 ? v5m : 32'h0);
      rd_chk(bsic_pkg::OFS_DEC_UPMAP, kind == 2'h3 ? upm : 32'h0);
      dec(w0 ^ 32'h00000004, w1, w2, 1'b0);
      chk(st & 32'h3, 32'h3);
      dec(w0 ^ 32'h00000100, w1, w2, 1'b0);
      chk(st & 32'h3F, 32'h05);
      case (kind)
        2'h1: begin
          dec(w0, w1, w2, 1'b1);
          chk(st & 32'h3F, uslot > 5'h02 ? 32'h11 : 32'h01);
          dec(w0 & 32'hFFE0FFFF, w1, w2, 1'b0);
          chk(st & 32'h3F, 32'h09);
        end
        2'h2: begin
          dec(w0 | 32'h80000000, w1, w2, 1'b0);
          chk(st & 32'h3F, 32'h09);
        end
        default: begin
          dec(w0, w1, w2, 1'b1);
          chk(st & 32'h3F, upm[31:3] != 0 ? 32'h11 : 32'h01);
          dec(w0, w1 ^ 32'h00020000, w2, 1'b0);
          chk(st & 32'h3F, 32'h21);
          dec(w0, w1 | 32'h00010000, w2, 1'b0);
          chk(st & 32'h3F, 32'h09);
        end
      endcase
    end
    // Encode with no kind: blank image, start bits never read back
    wr(bsic_pkg::OFS_CTRL, 32'hABCD0001);
    repeat (2) @(posedge hclk);
    rd_chk(bsic_pkg::OFS_STATUS, 32'h00000003);
    rd_chk(bsic_pkg::OFS_OCT_W0, 32'h00000000);
    rd_chk(bsic_pkg::OFS_CTRL, 32'hABCD0000);
    final_report();
  end
endmodule : bsic_tb_top

/* File: rtl/bsic_pkg.sv */
/*
  Constants for the bearer slot element codec: register offsets, element
  identifiers, fixed lengths and field positions.
  Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
*/
// Overview of operation
// RULE_01: The ISDN port slot element is 3 octets and names one user slot.
// RULE_02: Its user slot number is a five-bit binary field.
// RULE_03: Primary rate channels 1 to 31 take slot codes 00001 to 11111.
// RULE_04: Basic access channels 1 and 2 take slot codes 00001 and 00010.
// RULE_05: The single V5 slot element is 4 octets and names one V5 slot.
// RULE_06: The link identifier is eight bits, addressing up to 256 links.
// RULE_07: The V5 slot number is five bits, single slot or block start.
// RULE_08: The override flag is 0 for none and 1 for replace connection.
// RULE_09: The multi-slot map element is 11 octets for en-bloc work.
// RULE_10: Octets 4 to 7 are the V5 slot bitmap, 1 meaning affected.
// RULE_11: Octets 8 to 11 are the user slot bitmap, 1 meaning affected.
// RULE_12: Set bits of the two bitmaps pair one-to-one in ascending order.
// RULE_13: Each bitmap runs from slot 31 at its top bit to slot 1; bit 0 is 0.
// RULE_14: On basic access only user bitmap positions 1 and 2 may be set.
// RULE_15: Elements open with identifier and length; bad sizes are refused.
package bsic_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENC_FIELD = 8'h04;
  localparam logic [7:0] OFS_ENC_V5MAP = 8'h08;
  localparam logic [7:0] OFS_ENC_UPMAP = 8'h0C;
  localparam logic [7:0] OFS_OCT_W0 = 8'h10;
  localparam logic [7:0] OFS_OCT_W1 = 8'h14;
  localparam logic [7:0] OFS_OCT_W2 = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_DEC_FIELD = 8'h20;
  localparam logic [7:0] OFS_DEC_V5MAP = 8'h24;
  localparam logic [7:0] OFS_DEC_UPMAP = 8'h28;

  // Control register fields
  localparam int CTRL_ENCODE = 0;
  localparam int CTRL_DECODE = 1;
  localparam int CTRL_KIND_LO = 2;
  localparam int CTRL_BASIC = 4;

  // Field register layout (encode and decode)
  localparam int FLD_LINK_LO = 0;
  localparam int FLD_V5SLOT_LO = 8;
  localparam int FLD_OVERRIDE = 13;
  localparam int FLD_USLOT_LO = 16;

  // Status register bits
  localparam int ST_DONE = 0;
  localparam int ST_BAD_ID = 1;
  localparam int ST_BAD_LEN = 2;
  localparam int ST_BAD_CODE = 3;
  localparam int ST_BASIC = 4;
  localparam int ST_PAIR = 5;
  localparam int ST_KIND_LO = 8;

  localparam int OCT_COUNT = 12;

  typedef enum logic [1:0] {
    BSIC_KIND_NONE = 2'b00,
    BSIC_KIND_USLOT = 2'b01,
    BSIC_KIND_V5SLOT = 2'b10,
    BSIC_KIND_MAP = 2'b11
  } bsic_kind_t;

  localparam logic [7:0] ID_USLOT = 8'h41;
  localparam logic [7:0] ID_V5SLOT = 8'h42;
  localparam logic [7:0] ID_MAP = 8'h43;

  // Content length octet = total length minus identifier and length
  localparam logic [7:0] CLEN_USLOT = 8'h01;
  localparam logic [7:0] CLEN_V5SLOT = 8'h02;
  localparam logic [7:0] CLEN_MAP = 8'h09;

  localparam logic [4:0] BASIC_MAX_SLOT = 5'h02;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

endpackage : bsic_pkg

/* File: rtl/bsic_top.sv */
/*
  Bearer slot element codec: builds and checks the ISDN port slot, single
  V5 slot and multi-slot map elements in a twelve-octet buffer reached over
  AHB-Lite. Single clock hclk, asynchronous active-low reset hresetn.
  Assumes one master issuing single whole-word transfers.
*/
module bsic_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  logic [7:0] oct_ff [bsic_pkg::OCT_COUNT];
  logic [7:0] nxt_oct [bsic_pkg::OCT_COUNT];
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] enc_field_ff, nxt_enc_field;
  logic [31:0] enc_v5map_ff, nxt_enc_v5map;
  logic [31:0] enc_upmap_ff, nxt_enc_upmap;
  logic [31:0] status_ff, nxt_status;
  logic [31:0] dec_field_ff, nxt_dec_field;
  logic [31:0] dec_v5map_ff, nxt_dec_v5map;
  logic [31:0] dec_upmap_ff, nxt_dec_upmap;
  logic [31:0] rdata_ff, nxt_rdata;
  logic check_ff, nxt_check;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;

  logic addr_phase;
  logic [7:0] word_addr;

  function automatic logic [5:0] ones_in(input logic [31:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 1; i < 32; i++) begin
      n = n + {5'h00, m[i]};
    end
    return n;
  endfunction : ones_in

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (a)
      bsic_pkg::OFS_CTRL: w = ctrl_ff;
      bsic_pkg::OFS_ENC_FIELD: w = enc_field_ff;
      bsic_pkg::OFS_ENC_V5MAP: w = enc_v5map_ff;
      bsic_pkg::OFS_ENC_UPMAP: w = enc_upmap_ff;
      bsic_pkg::OFS_OCT_W0: w = {oct_ff[3], oct_ff[2], oct_ff[1], oct_ff[0]};
      bsic_pkg::OFS_OCT_W1: w = {oct_ff[7], oct_ff[6], oct_ff[5], oct_ff[4]};
      bsic_pkg::OFS_OCT_W2: w = {oct_ff[11], oct_ff[10], oct_ff[9], oct_ff[8]};
      bsic_pkg::OFS_STATUS: w = status_ff;
      bsic_pkg::OFS_DEC_FIELD: w = dec_field_ff;
      bsic_pkg::OFS_DEC_V5MAP: w = dec_v5map_ff;
      bsic_pkg::OFS_DEC_UPMAP: w = dec_upmap_ff;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction : read_word

  assign addr_phase = hsel & htrans[1] & hready;
  assign word_addr = {haddr[7:2], 2'b00};
  // Every transfer completes with no wait state
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // Bus slave: address phase captured, write committed in data phase
  always_comb begin
    nxt_wr_pend = addr_phase & hwrite;
    nxt_wr_addr = addr_phase ? word_addr : wr_addr_ff;
    nxt_rdata = rdata_ff;
    if (addr_phase && !hwrite) begin
      nxt_rdata = read_word(word_addr);
    end
  end

  // Encoding of the word fields into octets
  logic [7:0] image [bsic_pkg::OCT_COUNT];
  logic [1:0] enc_kind;
  logic [31:0] enc_fld;
  always_comb begin
    enc_fld = enc_field_ff;
    enc_kind = hwdata[bsic_pkg::CTRL_KIND_LO +: 2];
    for (int i = 0; i < bsic_pkg::OCT_COUNT; i++) begin
      image[i] = 8'h00;
    end
    unique case (enc_kind)
      bsic_pkg::BSIC_KIND_USLOT: begin
        image[0] = bsic_pkg::ID_USLOT; // RULE_15
        image[1] = bsic_pkg::CLEN_USLOT; // RULE_01
        image[2] = {3'b000, enc_fld[bsic_pkg::FLD_USLOT_LO +: 5]}; // RULE_02
      end
      bsic_pkg::BSIC_KIND_V5SLOT: begin
        image[0] = bsic_pkg::ID_V5SLOT;
        image[1] = bsic_pkg::CLEN_V5SLOT; // RULE_05
        image[2] = enc_fld[bsic_pkg::FLD_LINK_LO +: 8]; // RULE_06
        image[3] = {2'b00, enc_fld[bsic_pkg::FLD_OVERRIDE], // RULE_08
                    enc_fld[bsic_pkg::FLD_V5SLOT_LO +: 5]}; // RULE_07
      end
      bsic_pkg::BSIC_KIND_MAP: begin
        image[0] = bsic_pkg::ID_MAP;
        image[1] = bsic_pkg::CLEN_MAP; // RULE_09
        image[2] = enc_fld[bsic_pkg::FLD_LINK_LO +: 8];
        // Slot n sits at bit n; bit 0 forced low
        for (int k = 0; k < 4; k++) begin
          image[3 + k] = enc_v5map_ff[31 - 8 * k -: 8]; // RULE_10
          image[7 + k] = enc_upmap_ff[31 - 8 * k -: 8]; // RULE_11
        end
        image[6][0] = 1'b0; // RULE_13
        image[10][0] = 1'b0; // RULE_13
      end
      default: image[0] = 8'h00;
    endcase
  end

  // Checking and extraction of the octet buffer
  logic [1:0] chk_kind;
  logic bad_id, bad_len, bad_code, bad_basic, bad_pair;
  logic [31:0] v5map, upmap, fld;
  logic basic;
  always_comb begin
    basic = ctrl_ff[bsic_pkg::CTRL_BASIC];
    v5map = {oct_ff[3], oct_ff[4], oct_ff[5], oct_ff[6]}; // RULE_13
    upmap = {oct_ff[7], oct_ff[8], oct_ff[9], oct_ff[10]}; // RULE_13
    fld = 32'h00000000;
    chk_kind = bsic_pkg::BSIC_KIND_NONE;
    bad_id = 1'b0;
    bad_len = 1'b0;
    bad_code = 1'b0;
    bad_basic = 1'b0;
    bad_pair = 1'b0;
    unique case (oct_ff[0])
      bsic_pkg::ID_USLOT: begin
        chk_kind = bsic_pkg::BSIC_KIND_USLOT;
        bad_len = oct_ff[1] != bsic_pkg::CLEN_USLOT; // RULE_01
        fld[bsic_pkg::FLD_USLOT_LO +: 5] = oct_ff[2][4:0]; // RULE_02
        // Code 0 names no channel on either access type
        bad_code = (oct_ff[2][7:5] != 3'b000) || (oct_ff[2][4:0] == 5'h00); // RULE_03
        bad_basic = basic && (oct_ff[2][4:0] > bsic_pkg::BASIC_MAX_SLOT); // RULE_04
      end
      bsic_pkg::ID_V5SLOT: begin
        chk_kind = bsic_pkg::BSIC_KIND_V5SLOT;
        bad_len = oct_ff[1] != bsic_pkg::CLEN_V5SLOT; // RULE_05
        fld[bsic_pkg::FLD_LINK_LO +: 8] = oct_ff[2]; // RULE_06
        fld[bsic_pkg::FLD_V5SLOT_LO +: 5] = oct_ff[3][4:0]; // RULE_07
        fld[bsic_pkg::FLD_OVERRIDE] = oct_ff[3][5]; // RULE_08
        bad_code = oct_ff[3][7:6] != 2'b00;
      end
      bsic_pkg::ID_MAP: begin
        chk_kind = bsic_pkg::BSIC_KIND_MAP;
        bad_len = oct_ff[1] != bsic_pkg::CLEN_MAP; // RULE_09
        fld[bsic_pkg::FLD_LINK_LO +: 8] = oct_ff[2];
        bad_code = v5map[0] | upmap[0]; // RULE_13
        bad_basic = basic && (upmap[31:3] != 29'h00000000); // RULE_14
        // Ascending pairing only holds if both maps count alike
        bad_pair = ones_in(v5map) != ones_in(upmap); // RULE_12
      end
      default: bad_id = 1'b1; // RULE_15
    endcase
  end

  // Register file and codec sequencing
  logic start_enc, start_dec, ctrl_wr;
  always_comb begin
    ctrl_wr = wr_pend_ff && (wr_addr_ff == bsic_pkg::OFS_CTRL);
    start_enc = ctrl_wr && hwdata[bsic_pkg::CTRL_ENCODE];
    start_dec = ctrl_wr && hwdata[bsic_pkg::CTRL_DECODE];
    nxt_ctrl = ctrl_ff;
    nxt_enc_field = enc_field_ff;
    nxt_enc_v5map = enc_v5map_ff;
    nxt_enc_upmap = enc_upmap_ff;
    nxt_status = status_ff;
    nxt_dec_field = dec_field_ff;
    nxt_dec_v5map = dec_v5map_ff;
    nxt_dec_upmap = dec_upmap_ff;
    nxt_check = start_enc | start_dec;
    for (int i = 0; i < bsic_pkg::OCT_COUNT; i++) begin
      nxt_oct[i] = start_enc ? image[i] : oct_ff[i];
    end
    if (wr_pend_ff) begin
      unique case (wr_addr_ff)
        // Start bits self-clear; they never read back as set
        bsic_pkg::OFS_CTRL: nxt_ctrl = {hwdata[31:2], 2'b00};
        bsic_pkg::OFS_ENC_FIELD: nxt_enc_field = hwdata;
        bsic_pkg::OFS_ENC_V5MAP: nxt_enc_v5map = hwdata;
        bsic_pkg::OFS_ENC_UPMAP: nxt_enc_upmap = hwdata;
        bsic_pkg::OFS_OCT_W0: begin
          for (int b = 0; b < 4; b++) nxt_oct[b] = hwdata[8 * b +: 8];
        end
        bsic_pkg::OFS_OCT_W1: begin
          for (int b = 0; b < 4; b++) nxt_oct[4 + b] = hwdata[8 * b +: 8];
        end
        bsic_pkg::OFS_OCT_W2: begin
          for (int b = 0; b < 4; b++) nxt_oct[8 + b] = hwdata[8 * b +: 8];
        end
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (nxt_check) begin
      nxt_status = bsic_pkg::RESET_WORD;
    end
    if (check_ff) begin
      nxt_status = bsic_pkg::RESET_WORD;
      nxt_status[bsic_pkg::ST_DONE] = 1'b1;
      nxt_status[bsic_pkg::ST_BAD_ID] = bad_id;
      nxt_status[bsic_pkg::ST_BAD_LEN] = bad_len;
      nxt_status[bsic_pkg::ST_BAD_CODE] = bad_code;
      nxt_status[bsic_pkg::ST_BASIC] = bad_basic;
      nxt_status[bsic_pkg::ST_PAIR] = bad_pair;
      nxt_status[bsic_pkg::ST_KIND_LO +: 2] = chk_kind;
      nxt_dec_field = fld;
      nxt_dec_v5map = (chk_kind == bsic_pkg::BSIC_KIND_MAP) ? v5map : 32'h0;
      nxt_dec_upmap = (chk_kind == bsic_pkg::BSIC_KIND_MAP) ? upmap : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < bsic_pkg::OCT_COUNT; i++) oct_ff[i] <= 8'h00;
      ctrl_ff <= bsic_pkg::RESET_WORD;
      enc_field_ff <= bsic_pkg::RESET_WORD;
      enc_v5map_ff <= bsic_pkg::RESET_WORD;
      enc_upmap_ff <= bsic_pkg::RESET_WORD;
      status_ff <= bsic_pkg::RESET_WORD;
      dec_field_ff <= bsic_pkg::RESET_WORD;
      dec_v5map_ff <= bsic_pkg::RESET_WORD;
      dec_upmap_ff <= bsic_pkg::RESET_WORD;
      rdata_ff <= bsic_pkg::RESET_WORD;
      check_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      for (int i = 0; i < bsic_pkg::OCT_COUNT; i++) oct_ff[i] <= nxt_oct[i];
      ctrl_ff <= nxt_ctrl;
      enc_field_ff <= nxt_enc_field;
      enc_v5map_ff <= nxt_enc_v5map;
      enc_upmap_ff <= nxt_enc_upmap;
      status_ff <= nxt_status;
      dec_field_ff <= nxt_dec_field;
      dec_v5map_ff <= nxt_dec_v5map;
      dec_upmap_ff <= nxt_dec_upmap;
      rdata_ff <= nxt_rdata;
      check_ff <= nxt_check;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
    end
  end

endmodule : bsic_top
